// *** src/mbs_pkg.sv ***
// Purpose: Shared constants and types for the muxed bus-cycle sequencer
// Assumes: 40 MHz system clock, oscillator input at 10 MHz
// Notes: Timing figures are kept in their own units, cycle counts derive from them
package mbs_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned OSC_HZ = 10000000;
    localparam int unsigned STATE_NS = 200;
    localparam int unsigned CLK_NS = 25;
    // Cycles of clk in one machine state (200 ns / 25 ns)
    localparam int unsigned STATE_CYC = (STATE_NS + CLK_NS - 1) / CLK_NS;
    // Cycles of clk per oscillator half period; the divider toggles once every two of these
    localparam int unsigned OSC_HALF_CYC = CLK_HZ / (2 * OSC_HZ);
    // Cycle-type status codes
    localparam logic [1:0] CT_HALT = 2'h0;
    localparam logic [1:0] CT_WRITE = 2'h1;
    localparam logic [1:0] CT_READ = 2'h2;
    localparam logic [1:0] CT_FETCH = 2'h3;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_PC = 16'h0000;
    // Fetch lengths in states
    localparam int unsigned FETCH_SHORT = 4;
    localparam int unsigned FETCH_LONG = 6;
    localparam int unsigned MAX_CYCLES = 5;
    typedef enum logic [2:0] {
        MBS_IDLE,
        MBS_FIRST,
        MBS_SECOND,
        MBS_WAIT,
        MBS_THIRD,
        MBS_EXTRA
    } mbs_state_t;
endpackage

// *** src/mbs_sync.sv ***
// Purpose: Three-flop synchroniser with agreement filter for one pin input
// Assumes: Input is asynchronous to clk
// Notes: Output changes only when the second and third stages agree
`timescale 1ns/1ps
module mbs_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } mbs_sync_t;
    mbs_sync_t r_q;
    mbs_sync_t r_d;

    // First stage feeds only the second stage
    always_comb
    begin
        r_d = r_q;
        r_d.s1 = pin;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        if (r_q.s2 == r_q.s3)
        begin
            r_d.lvl = r_q.s3;
        end
    end

    // Register stage
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            r_q <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign level = r_q.lvl;
endmodule // mbs_sync

// *** src/mbs_seq.sv ***
// Purpose: Bus-cycle sequencer with shared address/data bus and ready waits
// Assumes: osc_input_pair sampled at 10 MHz level rate, one machine state = 8 clk
// Notes: Requests come from the core as valid levels with cycle kind and address, held until req_ready
// Behaviour
// - Sample ready at second state start
// - Ready low holds cycle before completion
// - Internal clock is oscillator divided by two
// - Internal clock driven on output pin
// - Reset clears int enable, hold ack, pc
// - Reset indicator asserted during reset
// - Instruction takes one to five cycles
// - Each machine state lasts 200 ns
// - Address latch pulse in first state
// - Low address only in first state
// - I/O flag held whole cycle for I/O
// - Status codes: 01 wr, 10 rd, 11 fetch, 00 halt
// - Status set at start, held stable
// - Read strobe after first state
// - Write strobe trailing edge in third state
// - Read/write cycles take three states
// - Fetch takes four or six states
// - Ready low inserts waits between second, third
// - High address lines stable all cycle
// - Strobes asserted second state, negated third
`timescale 1ns/1ps
module mbs_seq #(
    parameter int unsigned STATE_CYC = mbs_pkg::STATE_CYC,
    parameter int unsigned OSC_HALF_CYC = mbs_pkg::OSC_HALF_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic osc_input_pair,
    input wire logic ready,
    input wire logic reset_in_n,
    input wire logic req_valid,
    input wire logic [1:0] req_kind,
    input wire logic req_io,
    input wire logic req_long,
    input wire logic req_last,
    input wire logic [15:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic [7:0] ad_in,
    input wire logic int_enable_set,
    output logic req_ready,
    output logic [7:0] rdata,
    output logic rdata_valid,
    output logic [7:0] ad_out,
    output logic ad_oe,
    output logic [7:0] addr_hi,
    output logic addr_latch,
    output logic io_space,
    output logic cycle_type_hi,
    output logic cycle_type_lo,
    output logic rd_n,
    output logic wr_n,
    output logic clk_out,
    output logic reset_out,
    output logic int_enable,
    output logic hold_ack,
    output logic [15:0] pc,
    output logic [2:0] cycle_count
);
    initial
    begin
        if (STATE_CYC < 2 || OSC_HALF_CYC < 1 || STATE_CYC != 4 * OSC_HALF_CYC)
        begin
            $error("mbs_seq: state length must be four oscillator half periods");
        end
    end

    typedef struct packed {
        mbs_pkg::mbs_state_t st;
        logic [7:0] tick;
        logic [2:0] extra;
        logic [2:0] ncyc;
        logic [1:0] kind;
        logic io;
        logic lng;
        logic last;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic rvalid;
        logic rdy_ok;
        logic clkout;
        logic ie;
        logic ha;
        logic [15:0] pc;
        logic [7:0] ad_out;
        logic ad_oe;
        logic [7:0] ahi;
        logic ale;
        logic iof;
        logic [1:0] ct;
        logic rd_n;
        logic wr_n;
        logic rst_out;
        logic rq_rdy;
    } mbs_regs_t;
    mbs_regs_t r_q;
    mbs_regs_t r_d;
    logic ready_s;
    logic rstin_n_s;
    logic osc_s;
    logic osc_prev_q;
    logic osc_edge;
    logic state_end;
    logic state_start;

    // Pin inputs pass the three-flop agreement filter
    mbs_sync #(.RST_VAL(1'b1)) u_sync_ready (.clk(clk), .srst(srst), .pin(ready),
        .level(ready_s));
    mbs_sync #(.RST_VAL(1'b0)) u_sync_rst (.clk(clk), .srst(srst), .pin(reset_in_n),
        .level(rstin_n_s));
    mbs_sync #(.RST_VAL(1'b0)) u_sync_osc (.clk(clk), .srst(srst), .pin(osc_input_pair),
        .level(osc_s));

    // Rising oscillator edge detector on the filtered level
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            osc_prev_q <= 1'b0;
        end
        else
        begin
            osc_prev_q <= osc_s;
        end
    end
    assign osc_edge = osc_s & ~osc_prev_q;

    // State boundaries fall on tick wrap, giving 200 ns states
    assign state_end = (r_q.tick == 8'(STATE_CYC - 1));
    assign state_start = (r_q.tick == 8'h00);

    always_comb
    begin
        r_d = r_q;
        r_d.rvalid = 1'b0;
        r_d.ale = 1'b0;
        r_d.rq_rdy = 1'b0;
        // State timer; internal clock flips every half state, i.e. osc / 2
        if (state_end)
        begin
            r_d.tick = 8'h00;
        end
        else
        begin
            r_d.tick = r_q.tick + 8'h01;
        end
        if (osc_edge)
        begin
            r_d.clkout = ~r_q.clkout;
        end
        r_d.rst_out = ~rstin_n_s;
        if (int_enable_set)
        begin
            r_d.ie = 1'b1;
        end
        if (!rstin_n_s)
        begin
            // Device reset from the pin
            r_d.ie = 1'b0;
            r_d.ha = 1'b0;
            r_d.pc = mbs_pkg::RST_PC;
            r_d.st = mbs_pkg::MBS_IDLE;
            r_d.ct = mbs_pkg::CT_HALT;
            r_d.iof = 1'b0;
            r_d.rd_n = 1'b1;
            r_d.wr_n = 1'b1;
            r_d.ad_oe = 1'b0;
            r_d.ncyc = 3'h0;
        end
        else if (state_end)
        begin
            unique case (r_q.st)
                mbs_pkg::MBS_IDLE, mbs_pkg::MBS_THIRD, mbs_pkg::MBS_EXTRA:
                begin
                    r_d.rd_n = 1'b1;
                    r_d.wr_n = 1'b1;
                    r_d.ad_oe = 1'b0;
                    if (r_q.st == mbs_pkg::MBS_EXTRA && r_q.extra != 3'h0)
                    begin
                        r_d.extra = r_q.extra - 3'h1;
                    end
                    else if (req_valid)
                    begin
                        // New cycle: status, I/O flag and address set together
                        r_d.st = mbs_pkg::MBS_FIRST;
                        r_d.kind = req_kind;
                        r_d.io = req_io;
                        r_d.lng = req_long;
                        r_d.last = req_last;
                        r_d.addr = req_addr;
                        r_d.wdata = req_wdata;
                        r_d.ct = req_kind;
                        r_d.iof = req_io & (req_kind != mbs_pkg::CT_FETCH);
                        r_d.ahi = req_io ? req_addr[7:0] : req_addr[15:8];
                        r_d.ad_out = req_addr[7:0];
                        r_d.ad_oe = 1'b1;
                        r_d.ale = 1'b1;
                        r_d.rq_rdy = 1'b1;
                        if (req_kind == mbs_pkg::CT_FETCH)
                        begin
                            r_d.pc = req_addr + 16'h0001;
                        end
                    end
                    else
                    begin
                        r_d.st = mbs_pkg::MBS_IDLE;
                        r_d.ct = mbs_pkg::CT_HALT;
                        r_d.iof = 1'b0;
                    end
                end
                mbs_pkg::MBS_FIRST:
                begin
                    // Strobe after the first state; address leaves the shared bus
                    r_d.st = mbs_pkg::MBS_SECOND;
                    if (r_q.kind == mbs_pkg::CT_WRITE)
                    begin
                        r_d.wr_n = 1'b0;
                        r_d.ad_out = r_q.wdata;
                    end
                    else
                    begin
                        r_d.rd_n = 1'b0;
                        r_d.ad_oe = 1'b0;
                    end
                end
                mbs_pkg::MBS_SECOND, mbs_pkg::MBS_WAIT:
                begin
                    // Ready was caught at the start of this state
                    if (r_q.rdy_ok)
                    begin
                        r_d.st = mbs_pkg::MBS_THIRD;
                    end
                    else
                    begin
                        r_d.st = mbs_pkg::MBS_WAIT;
                    end
                end
                default:
                begin
                    r_d.st = mbs_pkg::MBS_IDLE;
                end
            endcase
        end
        // Ready sample at the start of second or wait state
        if (state_start && (r_q.st == mbs_pkg::MBS_SECOND || r_q.st == mbs_pkg::MBS_WAIT))
        begin
            r_d.rdy_ok = ready_s;
        end
        // Mid third state: strobes trail, read data captured on that edge
        if (r_q.st == mbs_pkg::MBS_THIRD && r_q.tick == 8'(STATE_CYC / 2 - 1)
            && rstin_n_s)
        begin
            r_d.wr_n = 1'b1;
            r_d.rd_n = 1'b1;
            if (r_q.kind != mbs_pkg::CT_WRITE)
            begin
                r_d.rdata = ad_in;
                r_d.rvalid = 1'b1;
            end
            // Fetch adds one or three states beyond the third
            if (r_q.kind == mbs_pkg::CT_FETCH)
            begin
                r_d.st = mbs_pkg::MBS_EXTRA;
                r_d.extra = r_q.lng ? 3'(mbs_pkg::FETCH_LONG - 3) : 3'(mbs_pkg::FETCH_SHORT - 3);
            end
            // Machine cycles counted per instruction, wrapping at its last
            if (r_q.last || r_q.ncyc == 3'(mbs_pkg::MAX_CYCLES - 1))
            begin
                r_d.ncyc = 3'h0;
            end
            else
            begin
                r_d.ncyc = r_q.ncyc + 3'h1;
            end
        end
    end

    // All sequencer state but the oscillator edge flop and the pin synchronisers in one register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            r_q <= '0;
            r_q.st <= mbs_pkg::MBS_IDLE;
            r_q.rd_n <= 1'b1;
            r_q.wr_n <= 1'b1;
            r_q.rst_out <= 1'b1;
            r_q.pc <= mbs_pkg::RST_PC;
            r_q.ad_out <= mbs_pkg::RST_BYTE;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign req_ready = r_q.rq_rdy;
    assign rdata = r_q.rdata;
    assign rdata_valid = r_q.rvalid;
    assign ad_out = r_q.ad_out;
    assign ad_oe = r_q.ad_oe;
    assign addr_hi = r_q.ahi;
    assign addr_latch = r_q.ale;
    assign io_space = r_q.iof;
    assign cycle_type_hi = r_q.ct[1];
    assign cycle_type_lo = r_q.ct[0];
    assign rd_n = r_q.rd_n;
    assign wr_n = r_q.wr_n;
    assign clk_out = r_q.clkout;
    assign reset_out = r_q.rst_out;
    assign int_enable = r_q.ie;
    assign hold_ack = r_q.ha;
    assign pc = r_q.pc;
    assign cycle_count = r_q.ncyc;

    chk_latch_first: assert property (@(posedge clk) disable iff (srst)
        r_q.ale |-> r_q.st == mbs_pkg::MBS_FIRST) else $error("latch outside first state");
    chk_ready_go: assert property (@(posedge clk) disable iff (srst || !rstin_n_s)
        (state_end && r_q.st == mbs_pkg::MBS_SECOND && r_q.rdy_ok)
        |=> r_q.st == mbs_pkg::MBS_THIRD) else $error("ready high did not proceed");
    chk_ready_hold: assert property (@(posedge clk) disable iff (srst || !rstin_n_s)
        (state_end && r_q.st inside {mbs_pkg::MBS_SECOND, mbs_pkg::MBS_WAIT} && !r_q.rdy_ok)
        |=> r_q.st == mbs_pkg::MBS_WAIT) else $error("ready low did not wait");
    chk_status_stable: assert property (@(posedge clk) disable iff (srst || !rstin_n_s)
        (r_q.st inside {mbs_pkg::MBS_SECOND, mbs_pkg::MBS_WAIT}) |-> $stable(r_q.ct))
        else $error("status changed mid cycle");
    chk_io_stable: assert property (@(posedge clk) disable iff (srst || !rstin_n_s)
        (r_q.st == mbs_pkg::MBS_SECOND) |-> $stable(r_q.iof) && $stable(r_q.ahi))
        else $error("io flag or high address moved");
    chk_rd_second: assert property (@(posedge clk) disable iff (srst || !rstin_n_s)
        (r_q.st == mbs_pkg::MBS_SECOND && r_q.kind != mbs_pkg::CT_WRITE) |-> !r_q.rd_n)
        else $error("read strobe missing in second state");
    chk_wr_trail: assert property (@(posedge clk) disable iff (srst)
        $rose(r_q.wr_n) |-> $past(r_q.st) == mbs_pkg::MBS_THIRD || !rstin_n_s)
        else $error("write strobe ended outside third state");
    chk_reset_clears: assert property (@(posedge clk) disable iff (srst)
        !rstin_n_s |=> !r_q.ie && !r_q.ha && r_q.pc == mbs_pkg::RST_PC && r_q.rst_out)
        else $error("reset did not clear state");
    chk_state_len: assert property (@(posedge clk) disable iff (srst)
        state_end |=> r_q.tick == 8'h00 ##7 state_end) else $error("state length wrong");
    cov_read: cover property (@(posedge clk) r_q.st == mbs_pkg::MBS_THIRD && r_q.kind == 2'h2);
    cov_write: cover property (@(posedge clk) r_q.st == mbs_pkg::MBS_THIRD && r_q.kind == 2'h1);
    cov_wait: cover property (@(posedge clk) r_q.st == mbs_pkg::MBS_WAIT);
    cov_fetch_long: cover property (@(posedge clk) r_q.st == mbs_pkg::MBS_EXTRA && r_q.lng);
endmodule // mbs_seq

// *** testbench/mbs_far_model.sv ***
// Purpose: Far-side model of ROM, RAM and I/O devices on the shared bus
// Assumes: RAM is the upper address half; I/O devices are slow as well
// Notes: An undriven bus shows the inverse of the last byte, never a held copy
`timescale 1ns/1ps
module mbs_far_model (
    input wire logic clk,
    input wire logic addr_latch,
    input wire logic [7:0] addr_hi,
    input wire logic [7:0] ad_out,
    input wire logic io_space,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [1:0] waits,
    output logic [7:0] ad_in,
    output logic ready,
    output logic [7:0] wr_byte
);
    logic [15:0] addr_q = 16'h0000;
    logic [7:0] last_q = 8'h00;
    logic wr_n_q = 1'b1;
    int hold_q = 0;
    // Capture address, run the not-ready window, latch write data
    always @(posedge clk)
    begin
        wr_n_q <= wr_n;
        if (addr_latch)
        begin
            addr_q <= {addr_hi, ad_out};
            // Window spans one ready sample per wait, from the second-state one, and ends before the next one
            hold_q <= (io_space || addr_hi[7]) ? 2 + 8 * waits : 0;
        end
        else if (hold_q > 0)
            hold_q <= hold_q - 1;
        if (wr_n && !wr_n_q)
            wr_byte <= ad_out;
        if (!rd_n)
            last_q <= ad_in;
    end
    assign ready = (hold_q == 0);
    // Data only while the read strobe is low
    assign ad_in = !rd_n ? (addr_q[7:0] ^ addr_q[15:8] ^ 8'h5a) : ~last_q;
endmodule // mbs_far_model

// *** testbench/test_muxed_bus_cycle_sequencer.sv ***
// Purpose: Self-checking bench for the muxed bus-cycle sequencer
// Assumes: Far-side model answers reads with a byte derived from the address
// Notes: Cycles are timed from one latch pulse to the next or to bus idle
`timescale 1ns/1ps
module test_muxed_bus_cycle_sequencer;
    typedef struct {logic [1:0] kind; logic io; logic [15:0] addr; logic [7:0] wd;
        logic last; int st;} mbs_exp_t;
    logic clk, srst, osc, ready, reset_in_n, req_valid, req_io, req_long, req_last, int_enable_set;
    logic [1:0] req_kind, waits;
    logic [15:0] req_addr, pc;
    logic [7:0] req_wdata, ad_in, rdata, ad_out, addr_hi, wr_byte;
    logic req_ready, rdata_valid, ad_oe, addr_latch, io_space, ct_hi, ct_lo, rd_n, wr_n;
    logic clk_out, reset_out, int_enable, hold_ack;
    logic [2:0] cycle_count;
    int bad_count, checked, cnt, n, i, w, ncyc_exp;
    logic act;
    mbs_exp_t cur;
    mbs_exp_t expq[$];

    mbs_seq mbs_seq_i (.clk(clk), .srst(srst), .osc_input_pair(osc), .ready(ready),
        .reset_in_n(reset_in_n), .req_valid(req_valid), .req_kind(req_kind), .req_io(req_io),
        .req_long(req_long), .req_last(req_last), .req_addr(req_addr), .req_wdata(req_wdata),
        .ad_in(ad_in), .int_enable_set(int_enable_set), .req_ready(req_ready), .rdata(rdata),
        .rdata_valid(rdata_valid), .ad_out(ad_out), .ad_oe(ad_oe), .addr_hi(addr_hi),
        .addr_latch(addr_latch), .io_space(io_space), .cycle_type_hi(ct_hi),
        .cycle_type_lo(ct_lo), .rd_n(rd_n), .wr_n(wr_n), .clk_out(clk_out),
        .reset_out(reset_out), .int_enable(int_enable), .hold_ack(hold_ack), .pc(pc),
        .cycle_count(cycle_count));
    mbs_far_model mbs_far_model_i (.clk(clk), .addr_latch(addr_latch), .addr_hi(addr_hi),
        .ad_out(ad_out), .io_space(io_space), .rd_n(rd_n), .wr_n(wr_n), .waits(waits),
        .ad_in(ad_in), .ready(ready), .wr_byte(wr_byte));

    // System clock, and an oscillator pin at 10 MHz with its own phase
    always #12.5 clk = ~clk;
    initial
    begin
        osc = 1'b0;
        #7;
        forever #50 osc = ~osc;
    end

    task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Queue the expectation first, then hold the request until it is taken
    task automatic do_cycle(input logic [1:0] k, input logic io, input logic lg,
        input logic [15:0] a, input logic [7:0] wd);
        mbs_exp_t e;
        e.kind = k;
        e.io = io;
        e.addr = a;
        e.wd = wd;
        e.st = (k == 2'h3) ? (lg ? 6 : 4) : 3 + ((io || a[15]) ? int'(waits) : 0);
        e.last = 1'($urandom % 2);
        expq.push_back(e);
        req_valid = 1'b1;
        req_kind = k;
        req_io = io;
        req_long = lg;
        req_addr = a;
        req_wdata = wd;
        req_last = e.last;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (req_ready !== 1'b1 && n < 200);
        if (n >= 200)
        begin
            check("req_taken", 1, 0);
            close_out();
        end
    endtask

    // Finish the open cycle: its length and any written byte
    task automatic finish_cycle();
        check("cycle_length", 16'(cur.st * 8), 16'(cnt));
        if (cur.kind == 2'h1)
            check("written_byte", cur.wd, wr_byte);
        // Count restarts after the last cycle of an instruction, or after the fifth
        ncyc_exp = (cur.last || ncyc_exp == 4) ? 0 : ncyc_exp + 1;
        act = 1'b0;
    endtask

    // Watcher: samples settled outputs, pops a note at each latch pulse
    always @(negedge clk)
    begin
        if (addr_latch === 1'b1)
        begin
            if (act)
                finish_cycle();
            if (expq.size() == 0)
                check("spare_cycle", 0, 1);
            else
            begin
                cur = expq.pop_front();
                act = 1'b1;
                cnt = 1;
                check("cycle_count", 16'(ncyc_exp), 16'(cycle_count));
                check("cycle_type", cur.kind, {ct_hi, ct_lo});
                check("io_space", cur.io, io_space);
                check("addr_hi", cur.addr[15:8], addr_hi);
                check("ad_address", {1'b1, cur.addr[7:0]}, {ad_oe, ad_out});
            end
        end
        else if (act)
        begin
            if ({ct_hi, ct_lo} === 2'h0)
                finish_cycle();
            else
            begin
                cnt++;
                check("cycle_type_held", cur.kind, {ct_hi, ct_lo});
                if (rd_n === 1'b0)
                    check("bus_released", 0, ad_oe);
                if (rdata_valid === 1'b1)
                    check("rdata", cur.addr[7:0] ^ cur.addr[15:8] ^ 8'h5a, rdata);
            end
        end
    end

    initial
    begin
        clk = 1'b0;
        srst = 1'b1;
        reset_in_n = 1'b1;
        req_valid = 1'b0;
        req_kind = 2'h2;
        {req_io, req_long, req_last, int_enable_set, act} = 5'h00;
        req_addr = 16'h0000;
        req_wdata = 8'h00;
        waits = 2'h1;
        bad_count = 0;
        checked = 0;
        void'($urandom(35));
        repeat (20) @(negedge clk);
        srst = 1'b0;
        // Reset pin filter needs a few clocks after release before reset_out drops
        repeat (8) @(negedge clk);
        check("strobes_idle", 2'h3, {rd_n, wr_n});
        check("pc_reset", 16'h0000, pc);
        check("flags_reset", 3'h0, {int_enable, hold_ack, reset_out});
        // Internal clock: 20 rising edges in 160 system clocks
        n = 0;
        cnt = (clk_out === 1'b1) ? 1 : 0;
        for (i = 0; i < 160; i++)
        begin
            @(negedge clk);
            if (clk_out === 1'b1 && cnt == 0)
                n++;
            cnt = (clk_out === 1'b1) ? 1 : 0;
        end
        check("clk_out_rises", 20, 16'(n));
        // Back-to-back random cycles, slow devices taking one wait, then three waits
        for (w = 1; w <= 3; w += 2)
        begin
            waits = 2'(w);
            for (i = 0; i < 15; i++)
            begin
                req_addr = 16'($urandom);
                req_io = (i % 3 != 2) && ($urandom % 2);
                if (req_io)
                    req_addr[15:8] = req_addr[7:0];
                if (i % 3 == 2)
                    req_addr[15] = 1'b0;
                do_cycle(2'(1 + i % 3), req_io, 1'($urandom % 2), req_addr, 8'($urandom));
            end
            req_valid = 1'b0;
            n = 0;
            while ((expq.size() != 0 || act) && n < 400)
            begin
                @(negedge clk);
                n++;
            end
            if (n >= 400)
            begin
                check("drain_timeout", 0, 1);
                close_out();
            end
            check("drained", 0, 16'(expq.size()));
        end
        // Device reset pin clears the enable flag and the program counter
        int_enable_set = 1'b1;
        @(negedge clk);
        int_enable_set = 1'b0;
        repeat (3) @(negedge clk);
        check("int_enable_set", 1, int_enable);
        reset_in_n = 1'b0;
        repeat (12) @(negedge clk);
        check("reset_held", 4'h8, {reset_out, int_enable, hold_ack, pc != 16'h0000});
        reset_in_n = 1'b1;
        repeat (12) @(negedge clk);
        check("reset_out_clear", 0, reset_out);
        close_out();
    end
endmodule // test_muxed_bus_cycle_sequencer
